/* File: rtl/sfd_flash_decoder.sv */
// serial flash command decoder with its program-data fifo
// Notes on behaviour
// - opcode 06 sets the write-enable latch
// - opcode 04 clears the write-enable latch
// - opcode 9F streams identity bytes while selected
// - opcode 05 repeats the status byte
// - opcode 01 plus byte writes status if enabled
// - opcode 03 reads array with no dummy clocks
// - opcode 0B reads after dummy clocks
// - opcode BB uses two lanes both ways
// - opcode EB uses four lanes after dummies
// - opcode 02 programs page at select rise
// - opcode 38 programs page over four lanes
// - opcode 20 plus address erases a sector
// - opcode D8 plus address erases a block
// - opcode 60 or C7 erases whole array
// - opcode B9 sleeps, ignoring all but wake
// - opcode AB returns signature, then wakes at select rise
// - opcodes 90, EF, DF read maker/device id
// - address bit zero picks first id, alternating
// - status reads zero after reset
`timescale 1ns/10ps

module sfd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
    logic push, pop;

    // extra pointer bit tells full from empty
    always_comb
    begin
        in_ready = (wp_reg ^ rp_reg) != {1'b1, {AW{1'b0}}};
        out_valid = wp_reg != rp_reg;
        out_data = mem[rp_reg[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
        if (push)
            mem[wp_reg[AW-1:0]] <= in_data;
    end
endmodule

module sfd_flash_decoder #(
    parameter int PWRUP_CYC = sfd_pkg::PWRUP_US * sfd_pkg::CLK_MHZ
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // serial pins from the host
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic [3:0] IO_IN,
    output sfd_pkg::sfd_io_t IO,
    // array read port
    output logic [23:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    input wire logic ARRAY_BUSY,
    // program data stream
    output sfd_pkg::sfd_prog_t PROG_WORD,
    output logic PROG_VALID,
    input wire logic PROG_READY,
    output logic PROG_COMMIT,
    output logic PROG_DROP,
    // erase, status write and power state
    output logic ERASE_REQ,
    output sfd_pkg::sfd_erase_t ERASE_CMD,
    output logic STATUS_WR,
    output logic [7:0] STATUS_VAL,
    output logic DEEP_SLEEP,
    output logic POWER_READY
);
    sfd_pkg::sfd_state_t st_reg, st_next;
    logic [5:0] s1_reg, s2_reg;
    logic sclk_d_reg, cs_d_reg;
    logic [7:0] cmd_reg, cmd_next, nb;
    logic [2:0] w_reg, w_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [23:0] acc_reg, acc_next, addr_reg, addr_next, sh;
    logic [7:0] ob_reg, ob_next;
    logic [3:0] oc_reg, oc_next, out_reg, out_next, oe_reg, oe_next;
    logic [1:0] idx_reg, idx_next;
    logic wel_reg, wel_next, done_reg, done_next, slp_reg, slp_next;
    logic [7:2] srw_reg, srw_next;
    logic drop_reg, drop_next, cmt_reg, cmt_next;
    logic ereq_reg, ereq_next, swr_reg, swr_next;
    sfd_pkg::sfd_erase_t ecmd_reg, ecmd_next;
    logic [13:0] pw_reg, pw_next;
    logic pok_reg, pok_next;
    logic rise, fall, csr, csf, op_done, push, push_rdy, wr_ok;
    logic [7:0] op_val, stat_byte;
    sfd_pkg::sfd_prog_t push_word;

    // shift one sclk's worth of lanes in, msb first
    function automatic logic [23:0] shift_in(logic [23:0] a, logic [2:0] w,
        logic [3:0] io);
        case (w)
            3'd1: shift_in = {a[22:0], io[0]};
            3'd2: shift_in = {a[21:0], io[1:0]};
            default: shift_in = {a[19:0], io};
        endcase
    endfunction

    // place the top bits of a byte on the lanes in use
    function automatic logic [3:0] lane_out(logic [7:0] b, logic [2:0] w);
        case (w)
            3'd1: lane_out = {2'b00, b[7], 1'b0};
            3'd2: lane_out = {2'b00, b[7:6]};
            default: lane_out = b[7:4];
        endcase
    endfunction

    // two-flop capture of pins; sclk and cs edges come from the second stage
    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            s1_reg <= 6'h3F;
            s2_reg <= 6'h3F;
            sclk_d_reg <= 1'b1;
            cs_d_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= {CS_N, SCLK, IO_IN};
            s2_reg <= s1_reg;
            sclk_d_reg <= s2_reg[4];
            cs_d_reg <= s2_reg[5];
        end
    end

    // edge events and byte sources
    always_comb
    begin
        rise = s2_reg[4] && !sclk_d_reg && !s2_reg[5];
        fall = !s2_reg[4] && sclk_d_reg && !s2_reg[5];
        csr = s2_reg[5] && !cs_d_reg;
        csf = !s2_reg[5] && cs_d_reg;
        sh = shift_in(acc_reg, w_reg, s2_reg[3:0]);
        op_val = sh[7:0];
        op_done = st_reg == sfd_pkg::ST_CMD && rise && cnt_reg == 6'd1;
        stat_byte = {srw_reg, wel_reg, ARRAY_BUSY};
        wr_ok = wel_reg && !ARRAY_BUSY;
        case (cmd_reg)
            sfd_pkg::OP_IDENT: nb = idx_reg == 2'd0 ? sfd_pkg::MAKER_ID :
                idx_reg == 2'd1 ? sfd_pkg::TYPE_ID : sfd_pkg::CAP_ID;
            sfd_pkg::OP_STAT_RD: nb = stat_byte;
            sfd_pkg::OP_WAKE: nb = sfd_pkg::SIGN_ID;
            sfd_pkg::OP_MDID_A, sfd_pkg::OP_MDID_B, sfd_pkg::OP_MDID_C:
                nb = idx_reg[0] ? sfd_pkg::SIGN_ID : sfd_pkg::MAKER_ID;
            default: nb = RD_DATA;
        endcase
        push_word = '{addr: addr_reg, data: sh[7:0]};
    end

    // main sequencer: next values of every control register
    always_comb
    begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        w_next = w_reg;
        cnt_next = cnt_reg;
        acc_next = acc_reg;
        addr_next = addr_reg;
        ob_next = ob_reg;
        oc_next = oc_reg;
        out_next = out_reg;
        oe_next = oe_reg;
        idx_next = idx_reg;
        wel_next = wel_reg;
        done_next = done_reg;
        slp_next = slp_reg;
        srw_next = srw_reg;
        drop_next = drop_reg;
        cmt_next = 1'b0;
        ereq_next = 1'b0;
        swr_next = 1'b0;
        ecmd_next = ecmd_reg;
        push = 1'b0;
        pok_next = pok_reg || pw_reg == 14'(PWRUP_CYC - 1);
        pw_next = pok_reg ? pw_reg : pw_reg + 14'd1;
        if (csf && pok_reg)
        begin
            st_next = sfd_pkg::ST_CMD;
            cnt_next = sfd_pkg::CMD_BITS;
            w_next = 3'd1;
            done_next = 1'b0;
            idx_next = 2'd0;
            oc_next = 4'd0;
        end
        else if (rise)
        begin
            acc_next = sh;
            cnt_next = cnt_reg - 6'(w_reg);
            unique case (st_reg)
                sfd_pkg::ST_CMD:
                    if (cnt_reg == 6'd1)
                    begin
                        cmd_next = op_val;
                        cnt_next = sfd_pkg::ADDR_BITS;
                        st_next = sfd_pkg::ST_ADDR;
                        done_next = 1'b1;
                        case (op_val)
                            sfd_pkg::OP_WRITE_ENABLE, sfd_pkg::OP_WRITE_DISABLE,
                            sfd_pkg::OP_CHIP_A, sfd_pkg::OP_CHIP_B,
                            sfd_pkg::OP_SLEEP:
                                st_next = sfd_pkg::ST_SKIP;
                            // wake keeps done set; 24 dummy clocks, then sign
                            sfd_pkg::OP_WAKE: ;
                            sfd_pkg::OP_IDENT, sfd_pkg::OP_STAT_RD:
                                st_next = sfd_pkg::ST_DOUT;
                            sfd_pkg::OP_STAT_WR:
                            begin
                                st_next = sfd_pkg::ST_DIN;
                                cnt_next = sfd_pkg::CMD_BITS;
                                done_next = 1'b0;
                            end
                            sfd_pkg::OP_DUAL: w_next = 3'd2;
                            sfd_pkg::OP_QUAD, sfd_pkg::OP_QPAGE:
                                w_next = 3'd4;
                            sfd_pkg::OP_READ, sfd_pkg::OP_FAST,
                            sfd_pkg::OP_PAGE, sfd_pkg::OP_SECT,
                            sfd_pkg::OP_BLOCK, sfd_pkg::OP_MDID_A,
                            sfd_pkg::OP_MDID_B, sfd_pkg::OP_MDID_C:
                                done_next = 1'b0;
                            default:
                            begin
                                st_next = sfd_pkg::ST_SKIP;
                                done_next = 1'b0;
                            end
                        endcase
                        if (op_val == sfd_pkg::OP_DUAL ||
                            op_val == sfd_pkg::OP_QUAD ||
                            op_val == sfd_pkg::OP_QPAGE)
                            done_next = 1'b0;
                        if (slp_reg && op_val != sfd_pkg::OP_WAKE)
                        begin
                            st_next = sfd_pkg::ST_SKIP;
                            done_next = 1'b0;
                        end
                    end
                sfd_pkg::ST_ADDR:
                    if (cnt_reg == 6'(w_reg))
                    begin
                        addr_next = sh;
                        idx_next = {1'b0, sh[0]};
                        st_next = sfd_pkg::ST_DOUT;
                        cnt_next = sfd_pkg::CMD_BITS;
                        case (cmd_reg)
                            sfd_pkg::OP_FAST:
                            begin
                                st_next = sfd_pkg::ST_DUMMY;
                                cnt_next = sfd_pkg::FAST_DUMMY;
                            end
                            sfd_pkg::OP_DUAL:
                            begin
                                st_next = sfd_pkg::ST_DUMMY;
                                cnt_next = sfd_pkg::DUAL_DUMMY;
                            end
                            sfd_pkg::OP_QUAD:
                            begin
                                st_next = sfd_pkg::ST_DUMMY;
                                cnt_next = sfd_pkg::QUAD_DUMMY;
                            end
                            sfd_pkg::OP_PAGE, sfd_pkg::OP_QPAGE:
                                st_next = sfd_pkg::ST_DIN;
                            sfd_pkg::OP_SECT, sfd_pkg::OP_BLOCK:
                            begin
                                st_next = sfd_pkg::ST_SKIP;
                                done_next = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                sfd_pkg::ST_DUMMY:
                begin
                    cnt_next = cnt_reg - 6'd1;  // dummies count clocks
                    if (cnt_reg == 6'd1)
                        st_next = sfd_pkg::ST_DOUT;
                end
                sfd_pkg::ST_DIN:
                    if (cnt_reg == 6'(w_reg))
                    begin
                        cnt_next = sfd_pkg::CMD_BITS;
                        done_next = 1'b1;
                        if (cmd_reg == sfd_pkg::OP_STAT_WR)
                        begin
                            srw_next = sh[7:2];  // held until select rise
                            st_next = sfd_pkg::ST_SKIP;
                        end
                        else if (wr_ok)
                        begin
                            push = 1'b1;
                            drop_next = drop_reg || !push_rdy;
                            // page address wraps inside the page
                            addr_next[7:0] = addr_reg[7:0] + 8'd1;
                        end
                    end
                default: ;
            endcase
        end
        else if (fall && st_reg == sfd_pkg::ST_DOUT)
        begin
            if (oc_reg == 4'd0)
            begin
                ob_next = nb << w_reg;
                out_next = lane_out(nb, w_reg);
                oc_next = 4'd8 - 4'(w_reg);
                oe_next = lane_out(8'hFF, w_reg);
                idx_next = idx_reg == 2'd2 ? 2'd0 : idx_reg + 2'd1;
                if (cmd_reg == sfd_pkg::OP_IDENT)
                    idx_next = idx_reg == 2'd2 ? 2'd0 : idx_reg + 2'd1;
                else
                    idx_next = {1'b0, !idx_reg[0]};
                addr_next = addr_reg + 24'd1;
            end
            else
            begin
                ob_next = ob_reg << w_reg;
                out_next = lane_out(ob_reg, w_reg);
                oc_next = oc_reg - 4'(w_reg);
            end
        end
        if (csr)
        begin
            st_next = sfd_pkg::ST_IDLE;
            oe_next = 4'h0;
            if (done_reg)
            begin
                case (cmd_reg)
                    sfd_pkg::OP_WRITE_ENABLE: wel_next = 1'b1;
                    sfd_pkg::OP_WRITE_DISABLE: wel_next = 1'b0;
                    sfd_pkg::OP_SLEEP: slp_next = 1'b1;
                    sfd_pkg::OP_WAKE: slp_next = 1'b0;
                    sfd_pkg::OP_STAT_WR:
                    begin
                        swr_next = wr_ok;
                        wel_next = 1'b0;
                    end
                    sfd_pkg::OP_PAGE, sfd_pkg::OP_QPAGE:
                    begin
                        cmt_next = wr_ok;
                        wel_next = 1'b0;
                    end
                    sfd_pkg::OP_SECT, sfd_pkg::OP_BLOCK, sfd_pkg::OP_CHIP_A,
                    sfd_pkg::OP_CHIP_B:
                    begin
                        ereq_next = wr_ok;
                        wel_next = 1'b0;
                        ecmd_next.addr = addr_reg;
                        ecmd_next.kind = cmd_reg == sfd_pkg::OP_SECT ?
                            sfd_pkg::ER_SECTOR : cmd_reg == sfd_pkg::OP_BLOCK ?
                            sfd_pkg::ER_BLOCK : sfd_pkg::ER_CHIP;
                    end
                    default: ;
                endcase
                if (cmd_reg == sfd_pkg::OP_STAT_WR && !wr_ok)
                    srw_next = srw_reg;
            end
            if (cmd_reg == sfd_pkg::OP_STAT_WR && !(done_reg && wr_ok))
                srw_next = srw_reg;
        end
        if (cmd_reg == sfd_pkg::OP_STAT_WR && !csr)
            srw_next = srw_reg;
        if (cmd_reg == sfd_pkg::OP_STAT_WR && csr && done_reg && wr_ok)
            srw_next = acc_reg[7:2];
    end

    // registers of the sequencer
    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            st_reg <= sfd_pkg::ST_IDLE;
            cmd_reg <= 8'h00;
            w_reg <= 3'd1;
            cnt_reg <= 6'd0;
            acc_reg <= 24'h000000;
            addr_reg <= 24'h000000;
            ob_reg <= 8'h00;
            oc_reg <= 4'h0;
            out_reg <= 4'h0;
            oe_reg <= 4'h0;
            idx_reg <= 2'd0;
            wel_reg <= sfd_pkg::STATUS_RST[sfd_pkg::WEL_BIT];
            done_reg <= 1'b0;
            slp_reg <= 1'b0;
            srw_reg <= sfd_pkg::STATUS_RST[7:2];
            drop_reg <= 1'b0;
            cmt_reg <= 1'b0;
            ereq_reg <= 1'b0;
            swr_reg <= 1'b0;
            ecmd_reg <= '0;
            pw_reg <= 14'd0;
            pok_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            w_reg <= w_next;
            cnt_reg <= cnt_next;
            acc_reg <= acc_next;
            addr_reg <= addr_next;
            ob_reg <= ob_next;
            oc_reg <= oc_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            idx_reg <= idx_next;
            wel_reg <= wel_next;
            done_reg <= done_next;
            slp_reg <= slp_next;
            srw_reg <= srw_next;
            drop_reg <= drop_next;
            cmt_reg <= cmt_next;
            ereq_reg <= ereq_next;
            swr_reg <= swr_next;
            ecmd_reg <= ecmd_next;
            pw_reg <= pw_next;
            pok_reg <= pok_next;
        end
    end

    // program bytes queue here; a stalled drain shows up as a drop
    sfd_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
        .clk(MCLK),
        .rst_n(RESETN),
        .in_valid(push),
        .in_ready(push_rdy),
        .in_data(push_word),
        .out_valid(PROG_VALID),
        .out_ready(PROG_READY),
        .out_data(PROG_WORD)
    );

    // outputs
    assign IO = '{o: out_reg, oe: oe_reg};
    assign RD_ADDR = addr_reg;
    assign PROG_COMMIT = cmt_reg;
    assign PROG_DROP = drop_reg;
    assign ERASE_REQ = ereq_reg;
    assign ERASE_CMD = ecmd_reg;
    assign STATUS_WR = swr_reg;
    assign STATUS_VAL = {srw_reg, wel_reg, ARRAY_BUSY};
    assign DEEP_SLEEP = slp_reg;
    assign POWER_READY = pok_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    sequence s_end(logic [7:0] op);
        csr && done_reg && cmd_reg == op;
    endsequence
    sequence s_one_pulse(logic p);
        p ##1 !p;
    endsequence
    a_latch_set: assert property (s_end(sfd_pkg::OP_WRITE_ENABLE)
        |=> wel_reg) else $error("write enable not latched");
    a_latch_clear: assert property (s_end(sfd_pkg::OP_WRITE_DISABLE)
        |=> !wel_reg) else $error("write enable not cleared");
    a_status_first_bit: assert property (fall && st_reg == sfd_pkg::ST_DOUT
        && cmd_reg == sfd_pkg::OP_STAT_RD && oc_reg == 4'd0
        |=> oe_reg == 4'h2 && out_reg[1] == $past(stat_byte[7]))
        else $error("status bit not driven on lane one");
    a_read_no_dummy: assert property (rise && st_reg == sfd_pkg::ST_ADDR
        && cmd_reg == sfd_pkg::OP_READ && cnt_reg == 6'd1
        |=> st_reg == sfd_pkg::ST_DOUT) else $error("plain read delayed");
    a_fast_dummies: assert property (rise && st_reg == sfd_pkg::ST_ADDR
        && cmd_reg == sfd_pkg::OP_FAST && cnt_reg == 6'd1
        |=> st_reg == sfd_pkg::ST_DUMMY && cnt_reg == 6'd8)
        else $error("fast read dummy count wrong");
    a_quad_lanes_on: assert property (fall && st_reg == sfd_pkg::ST_DOUT
        && cmd_reg == sfd_pkg::OP_QUAD |=> oe_reg == 4'hF)
        else $error("quad read not on four lanes");
    a_sleep_ignores: assert property (op_done && slp_reg
        && op_val != sfd_pkg::OP_WAKE |=> st_reg == sfd_pkg::ST_SKIP ##1
        !done_reg) else $error("command taken while asleep");
    a_sector_erase: assert property (s_end(sfd_pkg::OP_SECT) && wr_ok
        |=> s_one_pulse(ERASE_REQ) and ecmd_reg.kind == sfd_pkg::ER_SECTOR)
        else $error("sector erase not requested");
    a_unknown_ignored: assert property (op_done && op_val == 8'h00
        |=> st_reg == sfd_pkg::ST_SKIP && !done_reg)
        else $error("unknown opcode not ignored");
endmodule

/* File: rtl/sfd_pkg.sv */
// package: opcodes, timing, id bytes and carrier types of the flash decoder
package sfd_pkg;
    // one-byte opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_IDENT = 8'h9F;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DUAL = 8'hBB;
    localparam logic [7:0] OP_QUAD = 8'hEB;
    localparam logic [7:0] OP_PAGE = 8'h02;
    localparam logic [7:0] OP_QPAGE = 8'h38;
    localparam logic [7:0] OP_SECT = 8'h20;
    localparam logic [7:0] OP_BLOCK = 8'hD8;
    localparam logic [7:0] OP_CHIP_A = 8'h60;
    localparam logic [7:0] OP_CHIP_B = 8'hC7;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    localparam logic [7:0] OP_MDID_A = 8'h90;
    localparam logic [7:0] OP_MDID_B = 8'hEF;
    localparam logic [7:0] OP_MDID_C = 8'hDF;
    // serial framing, in bits or clocks
    localparam logic [5:0] CMD_BITS = 6'd8;
    localparam logic [5:0] ADDR_BITS = 6'd24;
    localparam logic [5:0] FAST_DUMMY = 6'd8;
    localparam logic [5:0] DUAL_DUMMY = 6'd4;
    localparam logic [5:0] QUAD_DUMMY = 6'd6;
    // power-up wait before the first command
    localparam int PWRUP_US = 200;
    localparam int CLK_MHZ = 50;
    // identity bytes: values are arbitrary
    localparam logic [7:0] MAKER_ID = 8'hA5;
    localparam logic [7:0] TYPE_ID = 8'h5A;
    localparam logic [7:0] CAP_ID = 8'h15;
    localparam logic [7:0] SIGN_ID = 8'h14;
    // status layout and delivery value
    localparam int WIP_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // erase kinds
    localparam logic [1:0] ER_SECTOR = 2'h0;
    localparam logic [1:0] ER_BLOCK = 2'h1;
    localparam logic [1:0] ER_CHIP = 2'h2;

    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DIN,
        ST_DOUT, ST_SKIP} sfd_state_t;
    typedef struct packed {logic [3:0] o; logic [3:0] oe;} sfd_io_t;
    typedef struct packed {logic [23:0] addr; logic [7:0] data;} sfd_prog_t;
    typedef struct packed {logic [1:0] kind; logic [23:0] addr;} sfd_erase_t;
endpackage

/* File: tb/sfd_host.sv */
// host controller model: mode 0 frames on one, two or four lanes, msb first
`timescale 1ns/10ps
module sfd_host (
    // serial pins toward the device
    output logic CS_N,
    output logic SCLK,
    output logic [3:0] IO_IN,
    // lane data from the device; a released lane reads inverted
    input wire logic [3:0] so
);
    // lanes for the bytes after the opcode
    int lanes = 1;
    initial
    begin
        CS_N = 1'b1;
        SCLK = 1'b0; // clock stands still between frames
        IO_IN = 4'h0;
    end
    // one frame; caller waits out power-up before the first one
    task automatic xfer(input logic [7:0] q[$], output logic [7:0] r[$]);
        logic [7:0] b;
        int n;
        r = {};
        CS_N = 1'b0;
        #80;
        foreach (q[k])
        begin
            n = k == 0 ? 1 : lanes; // opcode always on one lane
            for (int i = 7; i >= 0; i -= n)
            begin
                SCLK = 1'b0;
                // lanes stay driven, never floating
                for (int j = 0; j < n; j++)
                    IO_IN[j] = q[k][i - n + 1 + j];
                #80 SCLK = 1'b1;
                #80;
                // late in the bit: output settled
                for (int j = 0; j < n; j++)
                    b[i - n + 1 + j] = so[n == 1 ? 1 : j];
            end
            r.push_back(b);
        end
        SCLK = 1'b0;
        #80 CS_N = 1'b1;
        IO_IN = ~IO_IN; // released lines must not keep the last value
        #160;
    endtask
endmodule

/* File: tb/tb_top.sv */
// bench: host frames into the flash decoder, answers judged at the pins
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %h", $time, (a)); end end
module tb_top;
    logic MCLK = 1'b0;
    logic RESETN = 1'b0;
    logic PROG_READY = 1'b0;
    logic CS_N, SCLK, PROG_VALID, PROG_COMMIT, PROG_DROP, ERASE_REQ;
    logic DEEP_SLEEP, POWER_READY;
    logic [3:0] IO_IN;
    logic [7:0] r[$], q[$];
    sfd_pkg::sfd_io_t IO;
    sfd_pkg::sfd_prog_t PROG_WORD;
    sfd_pkg::sfd_erase_t ERASE_CMD, er;
    int fails = 0;
    int tests_run = 0;
    int n_er = 0;
    int n_cm = 0;
    always #10 MCLK = ~MCLK;
    // array tied to its erased value and never busy
    sfd_flash_decoder #(.PWRUP_CYC(20)) uut (.MCLK(MCLK), .RESETN(RESETN),
        .CS_N(CS_N), .SCLK(SCLK), .IO_IN(IO_IN), .IO(IO), .RD_ADDR(),
        .RD_DATA(8'hFF), .ARRAY_BUSY(1'b0), .PROG_WORD(PROG_WORD),
        .PROG_VALID(PROG_VALID), .PROG_READY(PROG_READY),
        .PROG_COMMIT(PROG_COMMIT), .PROG_DROP(PROG_DROP),
        .ERASE_REQ(ERASE_REQ), .ERASE_CMD(ERASE_CMD), .STATUS_WR(),
        .STATUS_VAL(), .DEEP_SLEEP(DEEP_SLEEP), .POWER_READY(POWER_READY));
    // a lane the device does not drive shows the inverse of its last value
    sfd_host h (.CS_N(CS_N), .SCLK(SCLK), .IO_IN(IO_IN), .so(IO.o ~^ IO.oe));
    // count one-cycle pulses so no frame has to catch them
    always @(posedge MCLK)
    begin
        if (ERASE_REQ === 1'b1) er <= ERASE_CMD;
        if (ERASE_REQ === 1'b1) n_er <= n_er + 1;
        if (PROG_COMMIT === 1'b1) n_cm <= n_cm + 1;
    end
    task automatic results();
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_status();
        for (int i = 0; i < 100 && POWER_READY !== 1'b1; i++) @(negedge MCLK);
        `CHK(POWER_READY, 1'b1)
        if (POWER_READY !== 1'b1) results();
        h.xfer('{8'h05, 8'h00, 8'h00}, r);
        `CHK({r[1], r[2]}, 16'h0000)
        h.xfer('{8'h06}, r);
        h.xfer('{8'h00, 8'h00}, r);
        h.xfer('{8'h05, 8'h00}, r);
        `CHK(r[1], 8'h02)
        h.xfer('{8'h04}, r);
        h.xfer('{8'h05, 8'h00}, r);
        `CHK(r[1], 8'h00)
    endtask
    task automatic t_reads();
        logic [7:0] ops[3] = '{8'h90, 8'hEF, 8'hDF};
        h.xfer('{8'h9F, 8'h00, 8'h00, 8'h00}, r);
        `CHK({r[1], r[2], r[3]}, {sfd_pkg::MAKER_ID, sfd_pkg::TYPE_ID, sfd_pkg::CAP_ID})
        h.xfer('{8'h03, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, r);
        `CHK({r[4], r[5]}, 16'hFFFF)
        // address bit zero picks which id comes first
        foreach (ops[i])
        begin
            h.xfer('{ops[i], 8'h00, 8'h00, 8'(i), 8'h00, 8'h00}, r);
            `CHK({r[4], r[5]}, i == 1 ? {sfd_pkg::SIGN_ID, sfd_pkg::MAKER_ID} : {sfd_pkg::MAKER_ID, sfd_pkg::SIGN_ID})
        end
    endtask
    task automatic t_lanes();
        h.lanes = 2;
        h.xfer('{8'hBB, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, r);
        `CHK(r[5], 8'hFF)
        h.lanes = 4;
        h.xfer('{8'hEB, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00}, r);
        `CHK(r[7], 8'hFF)
        h.lanes = 1;
    endtask
    task automatic t_erase();
        logic [7:0] eo[4] = '{8'h20, 8'hD8, 8'h60, 8'hC7};
        logic [1:0] ek[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        h.xfer('{8'hD8, 8'h01, 8'h23, 8'h45}, r);
        `CHK(n_er, 0)
        foreach (eo[i])
        begin
            q = '{eo[i]};
            if (i < 2) q = {q, 8'h01, 8'h23, 8'h45};
            h.xfer('{8'h06}, r);
            h.xfer(q, r);
            `CHK({er.kind, n_er}, {ek[i], i + 1})
            if (i < 2) `CHK(er.addr, 24'h012345)
        end
    endtask
    task automatic t_prog();
        h.xfer('{8'h06}, r);
        q = '{8'h02, 8'h00, 8'h00, 8'hFE};
        for (int k = 1; k < 10; k++) q.push_back(8'(k));
        h.xfer(q, r); // nine bytes into eight places, drain stalled
        `CHK({PROG_DROP, n_cm}, {1'b1, 32'h1})
        `CHK(PROG_WORD, {24'h0000FE, 8'h01})
        PROG_READY = 1'b1;
        for (int k = 0; k < 40 && PROG_VALID !== 1'b0; k++) @(negedge MCLK);
        `CHK(PROG_VALID, 1'b0)
        if (PROG_VALID !== 1'b0) results();
    endtask
    task automatic t_sleep();
        h.xfer('{8'hB9}, r);
        `CHK(DEEP_SLEEP, 1'b1)
        h.xfer('{8'h06}, r);
        h.xfer('{8'hAB, 8'h00, 8'h00, 8'h00, 8'h00}, r);
        `CHK({DEEP_SLEEP, r[4]}, {1'b0, sfd_pkg::SIGN_ID})
        h.xfer('{8'h05, 8'h00}, r);
        `CHK(r[1], 8'h00)
        h.xfer('{8'h06}, r);
        h.xfer('{8'h01, 8'h1C}, r);
        h.xfer('{8'h05, 8'h00}, r);
        `CHK(r[1], 8'h1C)
    endtask
    initial
    begin
        repeat (2) @(negedge MCLK);
        RESETN = 1'b1;
        t_status();
        t_reads();
        t_lanes();
        t_erase();
        t_prog();
        t_sleep();
        results();
    end
endmodule
